// ---- rtl/rcu_regs.vh ----
`ifndef RCU_REGS_VH
`define RCU_REGS_VH
// ==========================================
// Timing
`define RCU_CLK_PERIOD_PS 5000
`define RCU_HW_PULSE_MIN_NS 100
// Least low time rounds up to whole cycles
`define RCU_HW_PULSE_CYC ((`RCU_HW_PULSE_MIN_NS * 1000 + `RCU_CLK_PERIOD_PS - 1) / `RCU_CLK_PERIOD_PS)
`define RCU_SEQ_LEN_CYC 16
// ==========================================
// Boot option codes
`define RCU_BOOT_USER 2'h0
`define RCU_BOOT_LOADER 2'h1
`define RCU_BOOT_DEBUG 2'h2
`define RCU_BOOT_JTAG_USER 2'h3
`define RCU_BOOT_START_ADDR 16'h0000
// ==========================================
// Cause bit positions
`define RCU_CAUSE_POR 0
`define RCU_CAUSE_HW 1
`define RCU_CAUSE_WDT 2
`define RCU_CAUSE_WAKE 3
`define RCU_CAUSE_BROWN 4
`define RCU_CAUSE_RESET 5'h00
`endif

// ---- rtl/rcu_sync3.v ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Three-stage input synchroniser; change taken once stages two and three agree
module rcu_sync3 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!resetn) begin
          s1[i] <= INIT[i];
          s2[i] <= INIT[i];
          s3[i] <= INIT[i];
          dout[i] <= INIT[i];
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/rcu_reset_control_unit.v ----
// What this block does
// - Five causes each start a device reset
// - Latch boot pins at sequence end; keep
// - Reset pin low 100 ns is recognised
// - Pin reset works running or powered down
// - Watchdog malfunction signal resets the device
// - Pin or watchdog reset in power-down is wake-up; RAM kept
// - Active: both regulators; down: low-power only
// - Wake-up enables main regulator; watchdog keeps it
// - Two pins select four boot modes, start zero
`timescale 1ns/100ps
`default_nettype none
`include "rcu_regs.vh"
module rcu_reset_control_unit #(
  parameter HW_PULSE_CYC = `RCU_HW_PULSE_CYC,
  parameter SEQ_LEN_CYC = `RCU_SEQ_LEN_CYC
) (
  input wire clk,
  input wire resetn,
  input wire powerOnReq,
  input wire resetPin_n,
  input wire watchdogFault,
  input wire brownoutDetect,
  input wire powerDownReq,
  input wire bootModePin,
  input wire testModeSelect,
  input wire bootSelectPortPin,
  output reg deviceReset_n,
  output reg [1:0] bootOption,
  output reg bootOptionValid,
  output wire [15:0] bootStartAddr,
  output reg [4:0] resetCause,
  output reg ramContentsValid,
  output reg mainRegulatorEn,
  output reg lowPowerRegulatorEn,
  output reg powerDown
);
  // ==========================================
  // States
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_HOLD = 3'b010;
  localparam [2:0] ST_RELEASE = 3'b100;

  wire pinSync;
  wire [2:0] bootPins;
  wire porSync;
  wire brownSync;

  // Asynchronous pins are filtered so a glitch cannot trigger a reset
  // The pin idles high, so its synchroniser starts high and no false low follows reset
  rcu_sync3 #(.WIDTH(1), .INIT(1'b1)) uPin (
    .clk(clk), .resetn(resetn), .din(resetPin_n), .dout(pinSync));
  rcu_sync3 #(.WIDTH(3), .INIT(3'b001)) uBoot (
    .clk(clk), .resetn(resetn),
    .din({bootSelectPortPin, testModeSelect, bootModePin}), .dout(bootPins));
  rcu_sync3 #(.WIDTH(1), .INIT(1'b1)) uPor (
    .clk(clk), .resetn(resetn), .din(powerOnReq), .dout(porSync));
  rcu_sync3 #(.WIDTH(1), .INIT(1'b0)) uBrown (
    .clk(clk), .resetn(resetn), .din(brownoutDetect), .dout(brownSync));

  // ==========================================
  // Pin low-time qualification
  // Saturates while the pin stays low, so a long hold keeps the reset asserted
  reg [15:0] lowCount;
  wire hwReset = (lowCount >= HW_PULSE_CYC[15:0]);
  always @(posedge clk) begin
    if (!resetn) begin
      lowCount <= 16'h0000;
    end else if (pinSync) begin
      lowCount <= 16'h0000;
    end else if (!hwReset) begin
      lowCount <= lowCount + 16'h0001;
    end
  end

  // ==========================================
  // Cause collection
  wire [4:0] causeNow;
  assign causeNow[`RCU_CAUSE_POR] = porSync;
  assign causeNow[`RCU_CAUSE_HW] = hwReset;
  assign causeNow[`RCU_CAUSE_WDT] = watchdogFault & ~powerDown;
  // A pin or watchdog reset taken while powered down counts as wake-up
  assign causeNow[`RCU_CAUSE_WAKE] = powerDown & (hwReset | watchdogFault);
  assign causeNow[`RCU_CAUSE_BROWN] = brownSync;
  wire anyCause = |causeNow;
  // Power-on and brownout are cold causes: RAM may have lost its contents
  wire coldCause = causeNow[`RCU_CAUSE_POR] | causeNow[`RCU_CAUSE_BROWN];
  // Pin reset and cold causes re-read the straps
  wire relatchCause = coldCause | causeNow[`RCU_CAUSE_HW];

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] seqCount;
  reg relatch;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (anyCause) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!anyCause && seqCount >= SEQ_LEN_CYC[15:0]) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        next_state = anyCause ? ST_HOLD : ST_RUN;
      end
      default: begin
        // An unknown code falls back to hold, the safe side
        next_state = ST_HOLD;
      end
    endcase
  end

  // Boot code from two of the three strap pins
  // The port pin is not decoded; with it high the mode pin still decides
  reg [1:0] pinMode;
  always @* begin
    case ({bootPins[1], bootPins[0]})
      2'b01: pinMode = `RCU_BOOT_USER;
      2'b00: pinMode = `RCU_BOOT_LOADER;
      2'b10: pinMode = `RCU_BOOT_DEBUG;
      2'b11: pinMode = `RCU_BOOT_JTAG_USER;
      default: pinMode = `RCU_BOOT_USER;
    endcase
  end

  // Every boot mode starts at address zero
  assign bootStartAddr = `RCU_BOOT_START_ADDR;

  // ==========================================
  // Sequencer state
  // Reset enters hold, so a full sequence always follows release
  always @(posedge clk) begin
    if (!resetn) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================
  // Hold counter
  // Any live cause restarts the count, so even a one-cycle pulse gets the full hold
  always @(posedge clk) begin
    if (!resetn) begin
      seqCount <= 16'h0000;
    end else if (anyCause) begin
      seqCount <= 16'h0000;
    end else if (state == ST_HOLD && seqCount < SEQ_LEN_CYC[15:0]) begin
      seqCount <= seqCount + 16'h0001;
    end
  end

  // ==========================================
  // Device reset, cause record and RAM state
  always @(posedge clk) begin
    if (!resetn) begin
      deviceReset_n <= 1'b0;
      resetCause <= `RCU_CAUSE_RESET;
      ramContentsValid <= 1'b0;
    end else if (anyCause) begin
      deviceReset_n <= 1'b0;
      resetCause <= resetCause | causeNow;
      if (coldCause) begin
        ramContentsValid <= 1'b0;
      end
    end else if (state == ST_RELEASE) begin
      // Single clocked release so all logic leaves reset together
      deviceReset_n <= 1'b1;
      ramContentsValid <= 1'b1;
    end
  end

  // ==========================================
  // Boot option latch
  // Watchdog resets and watchdog wake-ups keep the old option, so a running program sees one mode
  always @(posedge clk) begin
    if (!resetn) begin
      relatch <= 1'b1;
      bootOption <= `RCU_BOOT_USER;
      bootOptionValid <= 1'b0;
    end else if (state == ST_HOLD && next_state == ST_RELEASE) begin
      if (relatch) begin
        bootOption <= pinMode;
        relatch <= 1'b0;
      end
      bootOptionValid <= 1'b1;
    end else if (anyCause && relatchCause) begin
      relatch <= 1'b1;
      bootOptionValid <= 1'b0;
    end
  end

  // ==========================================
  // Regulators and power-down
  always @(posedge clk) begin
    if (!resetn) begin
      mainRegulatorEn <= 1'b1;
      lowPowerRegulatorEn <= 1'b1;
      powerDown <= 1'b0;
    end else begin
      // The low-power regulator never drops, or retained RAM would be lost
      lowPowerRegulatorEn <= 1'b1;
      if (anyCause) begin
        // A watchdog reset while running leaves the regulators as they are
        if (causeNow[`RCU_CAUSE_WAKE] || coldCause || causeNow[`RCU_CAUSE_HW]) begin
          mainRegulatorEn <= 1'b1;
          powerDown <= 1'b0;
        end
      end else if (state == ST_RUN && powerDownReq && !powerDown) begin
        // Power-down is only left through a reset
        powerDown <= 1'b1;
        mainRegulatorEn <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/rcu_reset_control_unit_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Reset checks
module rcu_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic watchdogFault,
  input wire logic brownoutDetect,
  input wire logic deviceReset_n,
  input wire logic [1:0] bootOption,
  input wire logic bootOptionValid,
  input wire logic [15:0] bootStartAddr,
  input wire logic [4:0] resetCause,
  input wire logic ramContentsValid,
  input wire logic mainRegulatorEn,
  input wire logic lowPowerRegulatorEn,
  input wire logic powerDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_start_addr: assert property (bootStartAddr == 16'h0000)
    else $error("start address");
  chk_wdt_resets: assert property (watchdogFault |-> ##[1:2] !deviceReset_n)
    else $error("watchdog reset");
  chk_brown_resets: assert property (brownoutDetect |-> ##[1:6] !deviceReset_n)
    else $error("brownout reset");
  chk_down_regs: assert property ($rose(powerDown) |-> !mainRegulatorEn && lowPowerRegulatorEn)
    else $error("down regulators");
  chk_wake_main: assert property ($fell(powerDown) |-> ##[0:2] mainRegulatorEn)
    else $error("wake regulator");
  chk_release_valid: assert property ($rose(deviceReset_n) |-> bootOptionValid)
    else $error("release valid");
  chk_boot_kept: assert property (deviceReset_n && $past(deviceReset_n) |-> $stable(bootOption))
    else $error("boot changed");
  chk_cause_sticky: assert property ((resetCause & $past(resetCause)) == $past(resetCause))
    else $error("cause dropped");
endmodule
bind rcu_reset_control_unit rcu_assertions chk_u (.clk, .resetn, .watchdogFault, .brownoutDetect,
  .deviceReset_n, .bootOption, .bootOptionValid, .bootStartAddr, .resetCause, .ramContentsValid,
  .mainRegulatorEn, .lowPowerRegulatorEn, .powerDown);
`default_nettype wire

// ---- tb/rcu_ext_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Reset pin circuit and strap pins
module rcu_ext_model (
  input wire logic clk,
  input wire logic pulseGo,
  input wire logic [7:0] pulseLen,
  input wire logic [2:0] strap,
  output logic resetPin_n,
  output logic bootModePin,
  output logic testModeSelect,
  output logic bootSelectPortPin
);
  logic [7:0] lowLeft = 8'h00;
  // Straps never float, so sampling always sees a level
  assign {bootModePin, testModeSelect, bootSelectPortPin} = strap;
  assign resetPin_n = (lowLeft == 8'h00);
  always @(posedge clk) begin
    if (pulseGo) begin
      lowLeft <= pulseLen;
    end else if (lowLeft != 8'h00) begin
      lowLeft <= lowLeft - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- tb/rcu_reset_control_unit_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench
module rcu_reset_control_unit_tb_top;
  logic clk = 1'b0, resetn = 1'b0, powerOnReq = 1'b1, watchdogFault = 1'b0;
  logic brownoutDetect = 1'b0, powerDownReq = 1'b0, pulseGo = 1'b0;
  logic [7:0] pulseLen = 8'h00;
  logic [2:0] strap = 3'h4;
  logic [2:0] straps [4] = '{3'h4, 3'h0, 3'h2, 3'h6};
  wire logic resetPin_n, bootModePin, testModeSelect, bootSelectPortPin, deviceReset_n;
  wire logic bootOptionValid, ramContentsValid, mainRegulatorEn, lowPowerRegulatorEn, powerDown;
  wire logic [1:0] bootOption;
  wire logic [4:0] resetCause;
  wire logic [15:0] bootStartAddr;
  int fail_count = 0, cmp_count = 0;
  initial forever #2.5 clk = ~clk;
  rcu_reset_control_unit dut_u (.clk, .resetn, .powerOnReq, .resetPin_n, .watchdogFault,
    .brownoutDetect, .powerDownReq, .bootModePin, .testModeSelect, .bootSelectPortPin,
    .deviceReset_n, .bootOption, .bootOptionValid, .bootStartAddr, .resetCause,
    .ramContentsValid, .mainRegulatorEn, .lowPowerRegulatorEn, .powerDown);
  rcu_ext_model ext_u (.clk, .pulseGo, .pulseLen, .strap, .resetPin_n, .bootModePin,
    .testModeSelect, .bootSelectPortPin);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hit(input logic [7:0] n);
    pulseLen = n;
    pulseGo = 1'b1;
    @(negedge clk);
    pulseGo = 1'b0;
  endtask
  // Bounded waits keep a stuck reset from hanging the run
  task automatic waitRel;
    int n;
    n = 0;
    while (deviceReset_n !== 1'b0 && n < 100) begin @(negedge clk); n++; end
    chk(deviceReset_n, 0);
    while (deviceReset_n !== 1'b1 && n < 400) begin @(negedge clk); n++; end
    chk(deviceReset_n, 1);
  endtask
  task automatic t_hw;
    hit(8'h13);
    repeat (40) @(negedge clk);
    chk(resetCause[1], 0);
    for (int i = 0; i < 4; i++) begin
      strap = straps[i];
      hit(8'h14);
      waitRel;
      chk(bootOption, i);
    end
    chk(resetCause, 5'h03);
    $display("pin test done");
  endtask
  task automatic t_wdt;
    strap = 3'h0;
    watchdogFault = 1'b1;
    @(negedge clk);
    watchdogFault = 1'b0;
    repeat (10) @(negedge clk);
    chk(deviceReset_n, 0);
    waitRel;
    chk(bootOption, 3);
    chk({ramContentsValid, mainRegulatorEn, resetCause[2]}, 3'h7);
    $display("watchdog test done");
  endtask
  task automatic t_pd;
    powerDownReq = 1'b1;
    @(negedge clk);
    powerDownReq = 1'b0;
    repeat (3) @(negedge clk);
    chk({powerDown, mainRegulatorEn, lowPowerRegulatorEn}, 3'h5);
    hit(8'h14);
    waitRel;
    chk({powerDown, mainRegulatorEn, ramContentsValid, resetCause[3]}, 4'h7);
    $display("wake test done");
  endtask
  task automatic t_brown;
    brownoutDetect = 1'b1;
    repeat (10) @(negedge clk);
    brownoutDetect = 1'b0;
    waitRel;
    chk({resetCause[4], bootOption}, 3'h5);
    $display("brownout test done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    // A short power-on request stands in for the long pin hold while the supply settles
    repeat (4) @(negedge clk);
    powerOnReq = 1'b0;
    waitRel;
    chk({bootOption, bootOptionValid, ramContentsValid, resetCause}, 9'h061);
    chk(bootStartAddr, 16'h0000);
    $display("power-on test done");
    t_hw;
    t_wdt;
    t_pd;
    t_brown;
    print_verdict;
  end
endmodule
`default_nettype wire
